// >>> common/swsr_pkg.sv
package swsr_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFF_MODE_CFG    = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h18;
  localparam logic [7:0] OFF_CS_CFG0     = 8'h30;
  localparam logic [7:0] OFF_CS_CFG3     = 8'h3C;
  localparam logic [7:0] OFF_VIOL_STATUS = 8'hE8;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'hEC;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'hF0;
  localparam logic [7:0] OFF_OPTIONS     = 8'hF8;
  localparam logic [7:0] OFF_REVISION    = 8'hFC;

  localparam int unsigned NUM_CS = 4;

  // implemented_options fields
  localparam logic [31:0] OPTIONS_VALUE     = 32'h001F0154;
  localparam int unsigned OPT_SPUR_BIT      = 20;
  localparam int unsigned OPT_RXFIFO_BIT    = 19;
  localparam int unsigned OPT_BRIDGE_BIT    = 18;
  localparam int unsigned OPT_CSNA_BIT      = 17;
  localparam int unsigned OPT_EXTERNAL_DECODER_PRESENT_BIT    = 16;
  localparam int unsigned OPT_LEN_LSB       = 9;
  localparam int unsigned OPT_CHAR_LENGTH_ADJUSTABLE_BIT   = 8;
  localparam int unsigned OPT_PHZ_BIT       = 7;
  localparam int unsigned OPT_PHASE_ADJUSTABLE_BIT    = 6;
  localparam int unsigned OPT_PPOS_BIT      = 5;
  localparam int unsigned OPT_POLARITY_ADJUSTABLE_BIT     = 4;

  // module_revision: values arbitrary
  localparam logic [11:0] REV_NUMBER  = 12'h100;
  localparam logic [2:0]  REV_VARIANT = 3'h0;
  localparam int unsigned REV_VAR_LSB = 16;

  // violation_kind_code bits
  localparam int unsigned KIND_BLOCKED = 0;
  localparam int unsigned KIND_RESET   = 1;
  localparam int unsigned KIND_SPUR    = 2;
  localparam int unsigned SRC_LSB      = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       blocked;
    logic       sw_reset;
    logic       spurious;
    logic       clr_reset;
    logic [7:0] offset;
  } swsr_event_t;

endpackage : swsr_pkg

// >>> logic/swsr_event_sync.sv
`timescale 1ns/1ps
module swsr_event_sync
  import swsr_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  // three-stage path; a change counts once stages two and three agree
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_q[g]      <= 1'b0;
          s2_q[g]      <= 1'b0;
          s3_q[g]      <= 1'b0;
          level_out[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            level_out[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule : swsr_event_sync

// >>> logic/swsr_const_regs.sv
`timescale 1ns/1ps
module swsr_const_regs
  import swsr_pkg::*;
(
  input  wire logic [7:0]  rd_offset,
  output logic      [31:0] rd_value,
  output logic             rd_hit
);
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case (rd_offset)
      OFF_OPTIONS:  rd_value = OPTIONS_VALUE;
      OFF_REVISION: rd_value = {13'h0000, REV_VARIANT, 4'h0, REV_NUMBER};
      default:      rd_hit   = 1'b0;
    endcase
  end
endmodule : swsr_const_regs

// >>> logic/swsr_top.sv
`timescale 1ns/1ps
// Behaviour
// - a blocked or spurious write captures the bus offset of the register involved.
// - kind bit value 1 reports a write blocked by protection since the last read.
// - kind value 2 reports a software reset under protection until read or a mode, cs, irq enable or irq disable write.
// - kind value 4 reports a mode write with any select active or a cs write with it active.
// - coexisting kinds combine their codes by OR into values 3, 5, 6 and 7.
// - option bits report spurious guard, rx fifo, bridge type, cs deassert and decoder.
// - option bits report whether char length is adjustable and its fixed value.
// - option bits report whether phase is adjustable and whether the fixed phase is zero.
// - option bits report whether polarity is adjustable and whether it is positive.
// - the low option bits give the number of chip selects.
// - the options register reads as constant 0x001F0154.
// - the revision register reads a fixed 12-bit number and a reserved variant field.
module swsr_top
  import swsr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              prot_enable,
  input  wire logic              blocked_write,
  input  wire logic [7:0]        blocked_offset,
  input  wire logic              soft_reset,
  input  wire logic              cfg_write,
  input  wire logic [7:0]        cfg_write_offset,
  input  wire logic [NUM_CS-1:0] cs_active_pin,
  output logic                   irq
);

  swsr_event_t       ev;
  logic [NUM_CS-1:0] cs_active;
  logic [2:0]        kind_q;
  logic [7:0]        src_q;
  logic [2:0]        irq_status_q;
  logic [2:0]        irq_mask_q;
  logic              aw_done_q;
  logic              w_done_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  logic              rd_fire;
  logic              status_read;
  logic [31:0]       const_value;
  logic              const_hit;
  logic              mode_hit;
  logic              cs_hit;
  logic [1:0]        cs_index;
  logic              spur_now;
  logic [7:0]        viol_offset;

  // chip selects come from the pad ring, other clock domain
  swsr_event_sync #(.W(NUM_CS)) u_cs_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (cs_active_pin),
    .level_out (cs_active)
  );

  swsr_const_regs u_const (
    .rd_offset (s_axi_araddr),
    .rd_value  (const_value),
    .rd_hit    (const_hit)
  );

  // spurious write detection on mode and chip-select writes
  always_comb
  begin
    mode_hit = cfg_write && (cfg_write_offset == OFF_MODE_CFG);
    cs_hit   = cfg_write && (cfg_write_offset >= OFF_CS_CFG0)
               && (cfg_write_offset <= OFF_CS_CFG3);
    cs_index = cfg_write_offset[3:2];
    spur_now = (mode_hit && (|cs_active)) || (cs_hit && cs_active[cs_index]);
  end

  always_comb
  begin
    ev.blocked   = blocked_write;
    ev.sw_reset  = soft_reset && prot_enable;
    ev.spurious  = spur_now;
    ev.clr_reset = cfg_write && (mode_hit || cs_hit
                   || cfg_write_offset == OFF_IRQ_ENABLE
                   || cfg_write_offset == OFF_IRQ_DISABLE);
    ev.offset    = ev.spurious ? cfg_write_offset : blocked_offset;
    viol_offset  = ev.offset;
  end

  // AXI4-Lite: read answered in the cycle after arvalid is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign status_read   = rd_fire && (s_axi_araddr == OFF_VIOL_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == OFF_VIOL_STATUS)
        s_axi_rdata <= {16'h0000, src_q, 5'h00, kind_q};
      else if (s_axi_araddr == OFF_IRQ_STATUS)
        s_axi_rdata <= {29'h0, irq_status_q};
      else if (s_axi_araddr == OFF_IRQ_MASK)
        s_axi_rdata <= {29'h0, irq_mask_q};
      else if (const_hit)
        s_axi_rdata <= const_value;
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // write channels taken independently, response after both
  assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_done_q && !s_axi_bvalid;
  assign wr_fire       = aw_done_q && w_done_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_done_q <= 1'b0;
      w_done_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else if (wr_fire)
    begin
      aw_done_q <= 1'b0;
      w_done_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_done_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      // only the interrupt pair is writable; the rest is read-only
      s_axi_bresp  <= (aw_addr_q == OFF_IRQ_STATUS || aw_addr_q == OFF_IRQ_MASK)
                      ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // violation kind: events win over the clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      kind_q <= 3'h0;
    else
    begin
      kind_q[KIND_BLOCKED] <= ev.blocked || (kind_q[KIND_BLOCKED] && !status_read);
      kind_q[KIND_RESET]   <= ev.sw_reset
                              || (kind_q[KIND_RESET] && !status_read && !ev.clr_reset);
      kind_q[KIND_SPUR]    <= ev.spurious || (kind_q[KIND_SPUR] && !status_read);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_q <= 8'h00;
    else if (ev.blocked || ev.spurious)
      src_q <= viol_offset;
    else if (status_read)
      src_q <= 8'h00;
  end

  // sticky interrupt bits, write one to clear; a new event wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status_q <= 3'h0;
      irq_mask_q   <= 3'h0;
    end
    else
    begin
      irq_status_q <= {ev.spurious, ev.sw_reset, ev.blocked}
                      | (irq_status_q & ~((wr_fire && aw_addr_q == OFF_IRQ_STATUS
                                           && w_strb_q[0]) ? w_data_q[2:0] : 3'h0));
      if (wr_fire && aw_addr_q == OFF_IRQ_MASK && w_strb_q[0])
        irq_mask_q <= w_data_q[2:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  property p_blocked_sets;
    @(posedge aclk) disable iff (!aresetn)
      blocked_write |=> kind_q[KIND_BLOCKED];
  endproperty
  a_blocked_sets: assert property (p_blocked_sets) else $error("blocked flag missed");

  property p_reset_sets;
    @(posedge aclk) disable iff (!aresetn)
      (soft_reset && prot_enable) |=> kind_q[KIND_RESET];
  endproperty
  a_reset_sets: assert property (p_reset_sets) else $error("reset flag missed");

  property p_reset_clears;
    @(posedge aclk) disable iff (!aresetn)
      (ev.clr_reset && !ev.sw_reset) |=> !kind_q[KIND_RESET];
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset flag kept");

  property p_spur_sets;
    @(posedge aclk) disable iff (!aresetn)
      (mode_hit && |cs_active) |=> kind_q[KIND_SPUR];
  endproperty
  a_spur_sets: assert property (p_spur_sets) else $error("spurious flag missed");

  property p_cs_spur;
    @(posedge aclk) disable iff (!aresetn)
      (cs_hit && cs_active[cs_index]) |=> kind_q[KIND_SPUR];
  endproperty
  a_cs_spur: assert property (p_cs_spur) else $error("cs spurious flag missed");

  property p_src_spur;
    @(posedge aclk) disable iff (!aresetn)
      spur_now |=> (src_q == $past(cfg_write_offset));
  endproperty
  a_src_spur: assert property (p_src_spur) else $error("spurious source wrong");

  property p_src_capture;
    @(posedge aclk) disable iff (!aresetn)
      (blocked_write && !spur_now) |=> (src_q == $past(blocked_offset));
  endproperty
  a_src_capture: assert property (p_src_capture) else $error("source wrong");

  sequence s_status_read;
    status_read && !blocked_write && !ev.sw_reset && !spur_now;
  endsequence

  property p_read_clears;
    @(posedge aclk) disable iff (!aresetn)
      s_status_read |=> (kind_q == 3'h0) && (src_q == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_read_data;
    @(posedge aclk) disable iff (!aresetn)
      status_read |=> s_axi_rvalid && (s_axi_rdata[2:0] == $past(kind_q));
  endproperty
  a_read_data: assert property (p_read_data) else $error("status data wrong");

  property p_options;
    @(posedge aclk) disable iff (!aresetn)
      (rd_fire && s_axi_araddr == OFF_OPTIONS) |=> (s_axi_rdata == OPTIONS_VALUE);
  endproperty
  a_options: assert property (p_options) else $error("options value wrong");

  property p_revision;
    @(posedge aclk) disable iff (!aresetn)
      (rd_fire && s_axi_araddr == OFF_REVISION) |=> (s_axi_rdata[11:0] == REV_NUMBER)
        && (s_axi_rdata[REV_VAR_LSB +: 3] == REV_VARIANT) && (s_axi_rdata[31:19] == 13'h0000);
  endproperty
  a_revision: assert property (p_revision) else $error("revision value wrong");

endmodule : swsr_top

// >>> sim/swsr_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end

module swsr_top_tb;
  import swsr_pkg::*;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, prot_enable, blocked_write, soft_reset, cfg_write, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, blocked_offset, cfg_write_offset;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, seed, x;
  logic [3:0]  s_axi_wstrb, cs_active_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  int          m_kind, m_src, m_st, m_mask;
  logic [7:0]  cfgs [7] = '{OFF_MODE_CFG, OFF_IRQ_ENABLE, OFF_IRQ_DISABLE, OFF_CS_CFG0,
                            8'h34, 8'h38, OFF_CS_CFG3};

  swsr_top u_swsr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prot_enable, .blocked_write,
    .blocked_offset, .soft_reset, .cfg_write, .cfg_write_offset, .cs_active_pin, .irq);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task conclude();
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // handshakes sampled at the falling edge: settled values of the coming rising edge
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      resp_q = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask : axw

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    `CHK("rdata", e, rd_q)
    `CHK("rresp", er, resp_q)
  endtask : rchk

  task chk_irq();
    @(negedge aclk);
    `CHK("irq", (m_st & m_mask) != 0, irq)
    @(posedge aclk);
  endtask : chk_irq

  task ev(input logic b, r, c, pe, input logic [3:0] cs, input logic [7:0] bo, co);
    logic sp;
    logic rp;
    cs_active_pin <= cs;
    // cs pins pass a 4-flop synchroniser, so settle before the config write
    repeat (5) @(posedge aclk);
    blocked_write <= b;
    soft_reset <= r;
    prot_enable <= pe;
    cfg_write <= c;
    blocked_offset <= bo;
    cfg_write_offset <= co;
    @(posedge aclk);
    blocked_write <= 1'b0;
    soft_reset <= 1'b0;
    cfg_write <= 1'b0;
    rp = r && pe;
    sp = c && ((co == OFF_MODE_CFG && cs != 0) || (co >= OFF_CS_CFG0 && cs[co[3:2]]));
    if (c && !rp) m_kind &= ~2;
    m_kind |= b | (rp << 1) | (sp << 2);
    m_st |= b | (rp << 1) | (sp << 2);
    if (sp) m_src = co;
    else if (b) m_src = bo;
    chk_irq();
  endtask : ev

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {blocked_write, soft_reset, cfg_write} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    blocked_offset = 8'h00;
    cfg_write_offset = 8'h00;
    cs_active_pin = 4'h0;
    // protection level is redrawn with every event, mostly on
    prot_enable = 1'b1;
    seed = 32'h0000FD36;
    {m_kind, m_src, m_st, m_mask} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_VIOL_STATUS, 32'h00000000, RESP_OKAY);
    rchk(OFF_OPTIONS, 32'h001F0154, RESP_OKAY);
    rchk(OFF_REVISION, {13'h0000, REV_VARIANT, 4'h0, REV_NUMBER}, RESP_OKAY);
    rchk(8'h80, 32'h00000000, RESP_SLVERR);
    axw(OFF_OPTIONS, 32'hFFFFFFFF);
    `CHK("bresp", RESP_SLVERR, resp_q)
    rchk(OFF_OPTIONS, 32'h001F0154, RESP_OKAY);
    m_mask = 7;
    axw(OFF_IRQ_MASK, 32'h00000007);
    `CHK("bresp", RESP_OKAY, resp_q)
    rchk(OFF_IRQ_MASK, 32'h00000007, RESP_OKAY);
    for (int i = 0; i < 40; i++)
    begin
      x = xs();
      ev(x[0], x[1], x[2], x[23] | x[24], x[7:4], cfgs[x[10:8] % 7], cfgs[x[13:11] % 7]);
      if (x[14])
      begin
        rchk(OFF_VIOL_STATUS, (m_src << SRC_LSB) | m_kind, RESP_OKAY);
        m_kind = 0;
        m_src = 0;
      end
      if (x[15])
      begin
        rchk(OFF_IRQ_STATUS, m_st, RESP_OKAY);
        axw(OFF_IRQ_STATUS, {29'h00000000, x[18:16]});
        `CHK("bresp", RESP_OKAY, resp_q)
        m_st &= ~x[18:16];
      end
      if (x[19])
      begin
        m_mask = x[22:20];
        axw(OFF_IRQ_MASK, {29'h00000000, x[22:20]});
        `CHK("bresp", RESP_OKAY, resp_q)
      end
      chk_irq();
    end
    rchk(OFF_VIOL_STATUS, (m_src << SRC_LSB) | m_kind, RESP_OKAY);
    rchk(OFF_VIOL_STATUS, 32'h00000000, RESP_OKAY);
    conclude();
  end
endmodule : swsr_top_tb
